// File: hdl/phy_paged_register_map.sv
// Purpose: paged register bank of a three-port phy, reached over ahb-lite
// Assumes: all inputs synchronous to clk_in; single word transfers only
// Notes: every transfer takes one wait state so reads see prior writes
// Operation
// - sixteen registers selected by a four bit register index
// - indices 0 to 7 are fixed base registers, unaffected by page
// - indices 8 to F reach the selected one of eight pages
// - page select field of base register 7 chooses the page
// - base register field meanings never depend on the page
// - reserved registers and fields always read as zero
// - pages 2 through 6 read as zero everywhere
// - gap count is 3F on reset and after two bus resets unwritten
// - long reset request starts 166 us reset once idle; bus reset clears
// - root holdoff clears on hardware reset, survives bus reset
// - node address invalid from bus reset until self id done
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module phy_paged_register_map #(
  parameter int LONG_RESET_CYCLES = phy_regs_pkg::LONG_RESET_CYC
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  input wire logic [5:0] node_address_in,
  input wire logic root_in,
  input wire logic cable_power_in,
  input wire logic beta_link_in,
  input wire logic bus_reset_in,
  input wire logic self_id_done_in,
  input wire logic config_gap_wr_in,
  input wire logic [5:0] config_gap_in,
  input wire logic xfer_idle_in,
  output logic [5:0] gap_count_out,
  output logic root_holdoff_flag_out,
  output logic long_reset_active_out,
  output logic short_reset_request_out,
  output logic node_address_valid_out,
  output logic link_active_control_out,
  output logic standby_restore_allow_out,
  output logic [2:0] page_select_out,
  output logic [3:0] port_select_out
);
  // ==================================================================
  // bus front end
  logic phase_ff;
  logic wr_ff;
  logic unmapped_ff;
  logic [3:0] idx_ff;
  logic ready_ff;
  logic [31:0] rdata_ff;
  logic take;
  logic wr_go;

  // a transfer is taken only when the bus is ready and htrans says nonseq or seq
  assign take = hsel_in & htrans_in[1] & hready_in;
  assign wr_go = phase_ff & wr_ff & ~unmapped_ff;

  // capture the address phase; hsize is always a word here
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      phase_ff <= 1'b0;
      wr_ff <= 1'b0;
      unmapped_ff <= 1'b0;
      idx_ff <= 4'h0;
    end else begin
      phase_ff <= take;
      if (take) begin
        wr_ff <= hwrite_in;
        idx_ff <= haddr_in[phy_regs_pkg::IDX_MSB:phy_regs_pkg::IDX_LSB];
        unmapped_ff <= |haddr_in[31:phy_regs_pkg::ADDR_TOP_LSB];
      end
    end
  end

  // one wait state: ready drops in the cycle after the address is taken
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ready_ff <= 1'b1;
    end else begin
      ready_ff <= ~take;
    end
  end

  // ==================================================================
  // register state
  logic rhb_ff;
  logic ibr_ff;
  logic [5:0] gap_ff;
  logic gap_seen_ff;
  logic standby_restore_allow_ff;
  logic link_active_control_ff;
  logic cont_ff;
  logic [2:0] pwr_ff;
  logic [7:0] irq_ff;
  logic [1:0] bridge_ff;
  logic [2:0] page_ff;
  logic [3:0] port_ff;
  logic valid_ff;
  logic long_ff;
  logic [14:0] long_cnt_ff;
  logic [7:0] page_mem_ff [0:phy_regs_pkg::MEM_DEPTH-1];
  logic page_live;
  logic [1:0] slot;
  logic [4:0] mem_idx;
  logic gap_wr;

  // only pages 0, 1 and 7 hold storage; the rest are reserved
  always_comb begin
    page_live = 1'b1;
    slot = 2'd0;
    case (page_ff)
      phy_regs_pkg::PAGE_ZERO: slot = 2'd0;
      phy_regs_pkg::PAGE_ONE: slot = 2'd1;
      phy_regs_pkg::PAGE_SEVEN: slot = 2'd2;
      default: page_live = 1'b0;
    endcase
  end
  assign mem_idx = {slot, idx_ff[2:0]};

  assign gap_wr = wr_go & (idx_ff == phy_regs_pkg::IDX_GAP);

  // register 1: gap count, with the two-bus-reset fallback
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      gap_ff <= phy_regs_pkg::GAP_RESET;
      gap_seen_ff <= 1'b0;
    end else if (gap_wr) begin
      gap_ff <= hwdata_in[phy_regs_pkg::GAP_MSB:0];
      gap_seen_ff <= 1'b0;
    end else if (config_gap_wr_in) begin
      gap_ff <= config_gap_in;
      gap_seen_ff <= 1'b0;
    end else if (bus_reset_in) begin
      // second unwritten bus reset falls back to the slowest gap
      if (gap_seen_ff) begin
        gap_ff <= phy_regs_pkg::GAP_RESET;
      end
      gap_seen_ff <= 1'b1;
    end
  end

  // root holdoff: apart from register 1 writes, only hardware reset clears it
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rhb_ff <= 1'b0;
    end else if (gap_wr) begin
      rhb_ff <= hwdata_in[phy_regs_pkg::RHB_BIT];
    end
  end

  // long reset request and its 166 us timer; bus reset beats a write
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ibr_ff <= 1'b0;
      long_ff <= 1'b0;
      long_cnt_ff <= 15'h0000;
    end else begin
      if (bus_reset_in) begin
        ibr_ff <= 1'b0;
      end else if (gap_wr) begin
        ibr_ff <= hwdata_in[phy_regs_pkg::IBR_BIT];
      end else if (ibr_ff & xfer_idle_in & ~long_ff) begin
        ibr_ff <= 1'b0;
      end
      if (ibr_ff & xfer_idle_in & ~long_ff & ~bus_reset_in) begin
        long_ff <= 1'b1;
        long_cnt_ff <= 15'(LONG_RESET_CYCLES - 1);
      end else if (long_ff) begin
        if (long_cnt_ff == 15'h0000) begin
          long_ff <= 1'b0;
        end else begin
          long_cnt_ff <= long_cnt_ff - 15'h0001;
        end
      end
    end
  end

  // node address is untrusted from bus reset until self id completes
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      valid_ff <= 1'b0;
    end else if (self_id_done_in) begin
      valid_ff <= 1'b1;
    end else if (bus_reset_in) begin
      valid_ff <= 1'b0;
    end
  end

  // registers 3, 4 and 6: writable bits only; constants stay constant
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      standby_restore_allow_ff <= 1'b0;
      link_active_control_ff <= 1'b0;
      cont_ff <= 1'b0;
      pwr_ff <= 3'h0;
      bridge_ff <= 2'h0;
    end else if (wr_go) begin
      case (idx_ff)
        phy_regs_pkg::IDX_SPEED: standby_restore_allow_ff <= hwdata_in[phy_regs_pkg::STANDBY_RESTORE_ALLOW_BIT];
        phy_regs_pkg::IDX_LINK: begin
          link_active_control_ff <= hwdata_in[phy_regs_pkg::LINK_ACTIVE_CONTROL_BIT];
          cont_ff <= hwdata_in[phy_regs_pkg::CONT_BIT];
          pwr_ff <= hwdata_in[phy_regs_pkg::PWR_MSB:0];
        end
        phy_regs_pkg::IDX_LEGACY: begin
          bridge_ff <= hwdata_in[phy_regs_pkg::BRIDGE_MSB:phy_regs_pkg::BRIDGE_LSB];
        end
        default: ;
      endcase
    end
  end

  // register 5: enables; short reset request also drops on bus reset
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_ff <= 8'h00;
    end else if (wr_go & (idx_ff == phy_regs_pkg::IDX_IRQ)) begin
      irq_ff <= hwdata_in[7:0];
    end else if (bus_reset_in) begin
      irq_ff[phy_regs_pkg::SHORT_RESET_REQUEST_BIT] <= 1'b0;
    end
  end

  // register 7: page and port select, reserved bit dropped
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      page_ff <= 3'h0;
      port_ff <= 4'h0;
    end else if (wr_go & (idx_ff == phy_regs_pkg::IDX_PAGE)) begin
      page_ff <= hwdata_in[phy_regs_pkg::PAGE_MSB:phy_regs_pkg::PAGE_LSB];
      port_ff <= hwdata_in[phy_regs_pkg::PORT_MSB:0];
    end
  end

  // paged storage; writes to reserved pages are dropped
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < phy_regs_pkg::MEM_DEPTH; i++) begin
        page_mem_ff[i] <= 8'h00;
      end
    end else if (wr_go & idx_ff[phy_regs_pkg::PAGED_BIT] & page_live) begin
      page_mem_ff[mem_idx] <= hwdata_in[7:0];
    end
  end

  // ==================================================================
  // read path
  logic [7:0] rd_byte;

  // base bytes ignore the page setting entirely
  always_comb begin
    rd_byte = 8'h00;
    if (idx_ff[phy_regs_pkg::PAGED_BIT]) begin
      rd_byte = page_live ? page_mem_ff[mem_idx] : 8'h00;
    end else begin
      case (idx_ff)
        phy_regs_pkg::IDX_NODE: rd_byte = {node_address_in, root_in, cable_power_in};
        phy_regs_pkg::IDX_GAP: rd_byte = {rhb_ff, ibr_ff, gap_ff};
        phy_regs_pkg::IDX_EXT: rd_byte = {phy_regs_pkg::EXT_CODE, 1'b0, phy_regs_pkg::NUM_PORTS};
        phy_regs_pkg::IDX_SPEED: begin
          rd_byte = {phy_regs_pkg::SPEED_CODE, standby_restore_allow_ff, phy_regs_pkg::DELAY_CODE};
        end
        phy_regs_pkg::IDX_LINK: begin
          rd_byte = {link_active_control_ff, cont_ff, phy_regs_pkg::JITTER_CODE, pwr_ff};
        end
        phy_regs_pkg::IDX_IRQ: rd_byte = irq_ff;
        phy_regs_pkg::IDX_LEGACY: begin
          rd_byte = {phy_regs_pkg::LEGACY_SPD, beta_link_in, bridge_ff, 2'b00};
        end
        phy_regs_pkg::IDX_PAGE: rd_byte = {page_ff, 1'b0, port_ff};
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // read data is loaded in the wait cycle; upper bits and holes read zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_ff <= 32'h0000_0000;
    end else if (phase_ff) begin
      rdata_ff <= (wr_ff | unmapped_ff) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end
  end

  // ==================================================================
  // outputs
  assign hreadyout_out = ready_ff;
  assign hresp_out = 1'b0;
  assign hrdata_out = rdata_ff;
  assign gap_count_out = gap_ff;
  assign root_holdoff_flag_out = rhb_ff;
  assign long_reset_active_out = long_ff;
  assign short_reset_request_out = irq_ff[phy_regs_pkg::SHORT_RESET_REQUEST_BIT];
  assign node_address_valid_out = valid_ff;
  assign link_active_control_out = link_active_control_ff;
  assign standby_restore_allow_out = standby_restore_allow_ff;
  assign page_select_out = page_ff;
  assign port_select_out = port_ff;

  // ==================================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  wait_state_a: assert property (take |=> !hreadyout_out ##1 hreadyout_out)
    else $error("transfer did not take exactly one wait state");
  reserved_page_a: assert property (phase_ff && !wr_ff && !page_live
    && idx_ff[phy_regs_pkg::PAGED_BIT] |=> hrdata_out == 32'h0000_0000)
    else $error("reserved page read not zero");
  unmapped_read_a: assert property (phase_ff && unmapped_ff |=> hrdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");
  page_write_a: assert property (wr_go && idx_ff == phy_regs_pkg::IDX_PAGE
    |=> page_select_out == $past(hwdata_in[phy_regs_pkg::PAGE_MSB:phy_regs_pkg::PAGE_LSB]))
    else $error("page select not updated from write");
  gap_fallback_a: assert property (bus_reset_in && gap_seen_ff && !gap_wr
    && !config_gap_wr_in |=> gap_count_out == phy_regs_pkg::GAP_RESET)
    else $error("gap count missed fallback after two bus resets");
  ibr_clear_a: assert property (bus_reset_in |=> !ibr_ff)
    else $error("long reset request survived bus reset");
  long_start_a: assert property (ibr_ff && xfer_idle_in && !long_ff
    && !bus_reset_in |=> long_reset_active_out ##1 long_reset_active_out)
    else $error("long reset did not start");
  rhb_hold_a: assert property (bus_reset_in && !gap_wr |=> $stable(root_holdoff_flag_out))
    else $error("root holdoff changed on bus reset");
  addr_valid_a: assert property (bus_reset_in && !self_id_done_in
    ##1 !self_id_done_in[*2] |-> !node_address_valid_out)
    else $error("node address valid before self id");
  // bus events may legally move the gap count, so only a quiet cycle is judged
  rsvd_write_a: assert property (wr_go && idx_ff == phy_regs_pkg::IDX_EXT
    && !bus_reset_in && !config_gap_wr_in
    |=> $stable(gap_count_out) && $stable(page_select_out))
    else $error("reserved register write changed state");

  read_paged_c: cover property (phase_ff && !wr_ff && idx_ff[3] && page_live);
  long_reset_c: cover property (long_ff ##1 !long_ff);
  gap_fall_c: cover property (bus_reset_in ##[1:20] bus_reset_in);
endmodule // phy_paged_register_map

// File: hdl/phy_regs_pkg.sv
// Purpose: constants for the paged phy register bank
// Assumes: 8-bit registers, one per aligned 32-bit ahb word
// Notes: indices are register numbers; byte address is index times four
package phy_regs_pkg;
  // ==================================================================
  // register indices and bus decode
  localparam logic [3:0] IDX_NODE = 4'h0;
  localparam logic [3:0] IDX_GAP = 4'h1;
  localparam logic [3:0] IDX_EXT = 4'h2;
  localparam logic [3:0] IDX_SPEED = 4'h3;
  localparam logic [3:0] IDX_LINK = 4'h4;
  localparam logic [3:0] IDX_IRQ = 4'h5;
  localparam logic [3:0] IDX_LEGACY = 4'h6;
  localparam logic [3:0] IDX_PAGE = 4'h7;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 5;
  localparam int PAGED_BIT = 3;
  localparam int ADDR_TOP_LSB = 6;
  localparam int MEM_DEPTH = 24;
  // ==================================================================
  // field positions (byte bit 7 is the leftmost bit of a register)
  localparam int RHB_BIT = 7;
  localparam int IBR_BIT = 6;
  localparam int GAP_MSB = 5;
  localparam int STANDBY_RESTORE_ALLOW_BIT = 4;
  localparam int LINK_ACTIVE_CONTROL_BIT = 7;
  localparam int CONT_BIT = 6;
  localparam int PWR_MSB = 2;
  localparam int SHORT_RESET_REQUEST_BIT = 6;
  localparam int BRIDGE_MSB = 3;
  localparam int BRIDGE_LSB = 2;
  localparam int PAGE_MSB = 7;
  localparam int PAGE_LSB = 5;
  localparam int PORT_MSB = 3;
  // ==================================================================
  // fixed field values and reset values
  localparam logic [5:0] GAP_RESET = 6'h3F;
  localparam logic [2:0] EXT_CODE = 3'h7;
  localparam logic [3:0] NUM_PORTS = 4'h3;
  localparam logic [2:0] SPEED_CODE = 3'h7;
  localparam logic [3:0] DELAY_CODE = 4'hF;
  localparam logic [2:0] JITTER_CODE = 3'h0;
  localparam logic [2:0] LEGACY_SPD = 3'h0;
  localparam logic [2:0] PAGE_ZERO = 3'h0;
  localparam logic [2:0] PAGE_ONE = 3'h1;
  localparam logic [2:0] PAGE_SEVEN = 3'h7;
  // ==================================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int LONG_RESET_US = 166;
  localparam int LONG_RESET_CYC = (LONG_RESET_US * 1000) / CLK_PERIOD_NS;
endpackage : phy_regs_pkg

// File: verification/link_side_model.sv
// Purpose: far-side stand-in giving node status and bus events to the phy registers
// Assumes: events are one-cycle pulses launched by nba just after a rising edge
// Notes: status levels stay fixed except the idle level; the bench calls the tasks by hierarchy
`timescale 1ns/100ps
module link_side_model (
  input wire logic clk_in,
  output logic [5:0] node_address_out,
  output logic root_out,
  output logic cable_power_out,
  output logic beta_link_out,
  output logic bus_reset_out,
  output logic self_id_done_out,
  output logic config_gap_wr_out,
  output logic [5:0] config_gap_out,
  output logic xfer_idle_out
);
  // ==================================================================
  // status levels, a transfer is in progress until the bench says idle
  initial begin
    node_address_out = 6'h2D;
    root_out = 1'b1;
    cable_power_out = 1'b0;
    beta_link_out = 1'b1;
    bus_reset_out = 1'b0;
    self_id_done_out = 1'b0;
    config_gap_wr_out = 1'b0;
    config_gap_out = 6'h15;
    xfer_idle_out = 1'b0;
  end
  // ==================================================================
  // one pulse per call; gap bus shows its inverse once the strobe drops
  // so a design that samples it late sees a wrong value
  task automatic send_event(input logic br, input logic sid, input logic cw,
                            input logic [5:0] gap);
    @(posedge clk_in);
    bus_reset_out <= br;
    self_id_done_out <= sid;
    config_gap_wr_out <= cw;
    config_gap_out <= gap;
    @(posedge clk_in);
    bus_reset_out <= 1'b0;
    self_id_done_out <= 1'b0;
    config_gap_wr_out <= 1'b0;
    config_gap_out <= ~gap;
    repeat (2) @(posedge clk_in);
  endtask
  // idle level for the long reset gate
  task automatic set_idle(input logic v);
    @(posedge clk_in);
    xfer_idle_out <= v;
  endtask
endmodule // link_side_model

// File: verification/tb_phy_paged_register_map.sv
// Purpose: self-checking bench for the paged phy register bank over ahb-lite
// Assumes: hready is the slave's own hreadyout; long reset shortened to 8 cycles
// Notes: flags are looked at on the falling edge, and the long reset flag is also polled at rising edges; bus values at rising edges
`timescale 1ns/100ps
module tb_phy_paged_register_map;
  localparam int LR = 8;
  logic clk_in, srst_in, hsel, hwrite, hready, hresp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [5:0] node_addr, cfg_gap, gap;
  logic root, cable_power_flag, beta, brst, sid, cfg_wr, idle;
  logic root_holdoff_flag, lr_act, sr_req, nav, lac, sra;
  logic [2:0] page_sel;
  logic [3:0] port_sel;
  logic [7:0] ba[5] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h18};
  logic [7:0] bw[5] = '{8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] be[5] = '{8'hB6, 8'hE3, 8'hFF, 8'hC7, 8'h1C};
  int err_count, n_checks, n;
  phy_paged_register_map #(.LONG_RESET_CYCLES(LR)) i_dut (.clk_in(clk_in), .srst_in(srst_in),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready),
    .hresp_out(hresp), .hrdata_out(hrdata), .node_address_in(node_addr), .root_in(root),
    .cable_power_in(cable_power_flag), .beta_link_in(beta), .bus_reset_in(brst), .self_id_done_in(sid),
    .config_gap_wr_in(cfg_wr), .config_gap_in(cfg_gap), .xfer_idle_in(idle),
    .gap_count_out(gap), .root_holdoff_flag_out(root_holdoff_flag), .long_reset_active_out(lr_act),
    .short_reset_request_out(sr_req), .node_address_valid_out(nav),
    .link_active_control_out(lac), .standby_restore_allow_out(sra),
    .page_select_out(page_sel), .port_select_out(port_sel));
  link_side_model i_far (.clk_in(clk_in), .node_address_out(node_addr), .root_out(root),
    .cable_power_out(cable_power_flag), .beta_link_out(beta), .bus_reset_out(brst),
    .self_id_done_out(sid), .config_gap_wr_out(cfg_wr), .config_gap_out(cfg_gap),
    .xfer_idle_out(idle));
  // ==================================================================
  // clock and reset
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // ==================================================================
  // reporting
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ==================================================================
  // ahb master: hold address until ready, then data phase until ready
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk_in);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    rv = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h5A5A_5A, d});
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rv, {24'h0000_00, e});
  endtask
  // ==================================================================
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    close_out();
  end
  // ==================================================================
  // test sequence
  initial begin
    err_count = 0;
    n_checks = 0;
    srst_in = 1'b1;
    hsel = 1'b1;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(32'h0000_0004, 8'h3F);
    rd(32'h0000_001C, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 5; i++) begin
      wr({24'h0000_00, ba[i]}, bw[i]);
      rd({24'h0000_00, ba[i]}, be[i]);
    end
    @(negedge clk_in);
    chk({30'h0, lac, sra}, 32'h0000_0003);
    $display("test base registers done");
    for (int p = 0; p < 8; p++) begin
      wr(32'h0000_001C, {p[2:0], 5'h15});
      rd(32'h0000_001C, {p[2:0], 5'h05});
      wr(32'h0000_003C, 8'h60 + p[7:0]);
    end
    for (int p = 0; p < 8; p++) begin
      wr(32'h0000_001C, {p[2:0], 5'h05});
      @(negedge clk_in);
      chk({29'h0, page_sel}, p);
      rd(32'h0000_003C, (p < 2 || p == 7) ? 8'h60 + p[7:0] : 8'h00);
      rd(32'h0000_0008, 8'hE3);
    end
    $display("test page select done");
    wr(32'h0000_0044, 8'h00);
    rd(32'h0000_0044, 8'h00);
    rd(32'h0000_0004, 8'h3F);
    $display("test unmapped address done");
    wr(32'h0000_0004, 8'hCA);
    wr(32'h0000_0014, 8'h40);
    i_far.send_event(1'b0, 1'b1, 1'b0, 6'h00);
    @(negedge clk_in);
    chk({31'h0, nav}, 32'h0000_0001);
    chk({31'h0, sr_req}, 32'h0000_0001);
    i_far.send_event(1'b1, 1'b0, 1'b0, 6'h00);
    @(negedge clk_in);
    chk({31'h0, nav}, 32'h0000_0000);
    rd(32'h0000_0004, 8'h8A);
    rd(32'h0000_0014, 8'h00);
    i_far.send_event(1'b1, 1'b0, 1'b0, 6'h00);
    rd(32'h0000_0004, 8'hBF);
    i_far.send_event(1'b0, 1'b0, 1'b1, 6'h12);
    i_far.send_event(1'b1, 1'b0, 1'b0, 6'h00);
    rd(32'h0000_0004, 8'h92);
    // side outputs: okay response, holdoff set, gap 12h, port select 5
    @(negedge clk_in);
    chk({20'h0_0000, hresp, root_holdoff_flag, gap, port_sel}, 32'h0000_0525);
    $display("test bus reset effects done");
    wr(32'h0000_0004, 8'h4A);
    repeat (20) @(posedge clk_in);
    @(negedge clk_in);
    chk({31'h0, lr_act}, 32'h0000_0000);
    i_far.set_idle(1'b1);
    n = 0;
    for (int i = 0; i < 10 && lr_act !== 1'b1; i++) @(posedge clk_in);
    while (lr_act === 1'b1 && n < 100) begin
      n++;
      @(posedge clk_in);
    end
    chk(n, LR);
    rd(32'h0000_0004, 8'h0A);
    $display("test long reset done");
    close_out();
  end
endmodule // tb_phy_paged_register_map
